// ===== core/sia_top.v
`timescale 1ns/1ps
`include "sia_defines.vh"

module sia_top (
  input  wire        I_CLOCK,     // System clock, 20 MHz
  input  wire        I_RSTN,      // Async reset, active low
  input  wire        I_HSEL,      // Slave select
  input  wire [31:0] I_HADDR,     // Byte address
  input  wire [1:0]  I_HTRANS,    // Transfer type
  input  wire        I_HWRITE,    // Write when high
  input  wire [2:0]  I_HSIZE,     // Transfer size
  input  wire [31:0] I_HWDATA,    // Write data
  input  wire        I_HREADY,    // Bus ready in
  output wire        O_HREADYOUT, // Slave ready
  output wire        O_HRESP,     // Always OKAY
  output reg  [31:0] O_HRDATA,    // Read data
  input  wire        I_SDA,       // Data line level in
  output wire        O_SDA_O,     // Data line drive value
  output wire        O_SDA_OE_N,  // Data line drive enable, low drives
  input  wire        I_SCL,       // Clock line level in
  output wire        O_SCL_O,     // Clock line drive value
  output wire        O_SCL_OE_N,  // Clock line drive enable, low drives
  output reg         O_XFER_END   // Transfer end pulse
);

  // ==================================================
  // Bus phase and register state
  reg        ph_valid;
  reg        ph_write;
  reg  [7:0] ph_addr;
  reg        rd_done;
  reg [15:0] mode_cfg;
  reg [15:0] comm_set;
  reg [15:0] data_div;
  reg [15:0] out_lvl;
  reg [15:0] out_en;
  reg  [7:0] prescale;
  reg        chan_enabled;
  reg        ack_err;
  reg  [1:0] sda_sync;
  reg  [1:0] scl_sync;
  reg        start_req;

  wire       sh_busy;
  wire       sh_scl;
  wire       sh_sda;
  wire [7:0] sh_rx;
  wire       sh_done;
  wire       sh_ack_bad;
  wire       mck_tick;

  // Register write strobe in the data phase
  wire       wr_now = ph_valid && ph_write;
  wire       rd_now = ph_valid && !ph_write;

  // Address phase taken when selected, active and ready
  wire       addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;

  // Address match helper used by every register write decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ==================================================
  // AHB-Lite response: writes take no wait, reads take one
  // Registered read data costs one wait state but keeps timing clean
  assign O_HREADYOUT = !(rd_now && !rd_done);
  assign O_HRESP     = 1'b0;

  // Capture the address phase
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end else if (O_HREADYOUT) begin
      ph_valid <= addr_take;
      ph_write <= I_HWRITE;
      ph_addr  <= {I_HADDR[7:2], 2'b00};
    end
  end

  // Read wait-state tracker
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_done <= 1'b0;
    end else begin
      rd_done <= rd_now && !rd_done;
    end
  end

  // ==================================================
  // Read data mux, registered in the wait cycle
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_HRDATA <= 32'h00000000;
    end else if (rd_now && !rd_done) begin
      case (ph_addr)
        `SIA_OFS_MODE: begin
          O_HRDATA <= {16'h0000, mode_cfg};
        end
        `SIA_OFS_COMM: begin
          O_HRDATA <= {16'h0000, comm_set};
        end
        `SIA_OFS_DATA: begin
          O_HRDATA <= {16'h0000, data_div[15:8], sh_rx};
        end
        `SIA_OFS_OUTLVL: begin
          O_HRDATA <= {16'h0000, out_lvl};
        end
        `SIA_OFS_OUTEN: begin
          O_HRDATA <= {16'h0000, out_en};
        end
        `SIA_OFS_STATUS: begin
          O_HRDATA <= {25'h0000000, sh_busy, 4'h0, ack_err, 1'b0};
        end
        `SIA_OFS_PRESCALE: begin
          O_HRDATA <= {24'h000000, prescale};
        end
        `SIA_OFS_ENABLED: begin
          O_HRDATA <= {31'h00000000, chan_enabled};
        end
        default: begin
          O_HRDATA <= 32'h00000000;
        end
      endcase
    end
  end

  // ==================================================
  // Configuration registers; frozen fields are left to software
  // Parity and stop fields are stored as written, the engine
  // always runs eight bits plus one acknowledge slot
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_cfg <= `SIA_RST_MODE;
      comm_set <= `SIA_RST_COMM;
      out_lvl  <= `SIA_RST_OUTLVL;
      out_en   <= `SIA_RST_OUTEN;
      prescale <= `SIA_RST_PRESCALE;
    end else if (wr_now) begin
      if (hit(ph_addr, `SIA_OFS_MODE)) begin
        mode_cfg <= I_HWDATA[15:0];
      end
      if (hit(ph_addr, `SIA_OFS_COMM)) begin
        comm_set <= I_HWDATA[15:0];
      end
      if (hit(ph_addr, `SIA_OFS_OUTLVL)) begin
        out_lvl <= I_HWDATA[15:0];
      end
      if (hit(ph_addr, `SIA_OFS_OUTEN)) begin
        out_en <= I_HWDATA[15:0];
      end
      if (hit(ph_addr, `SIA_OFS_PRESCALE)) begin
        prescale <= I_HWDATA[7:0];
      end
    end
  end

  // ==================================================
  // Data and divider register; a write while enabled and not busy
  // launches the next frame of whatever operation kind
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      data_div  <= `SIA_RST_DATA;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (wr_now && hit(ph_addr, `SIA_OFS_DATA)) begin
        data_div  <= I_HWDATA[15:0];
        start_req <= chan_enabled && !sh_busy;
      end
    end
  end

  // ==================================================
  // Channel enable: start trigger sets, stop trigger clears
  // Start wins if both land together
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      chan_enabled <= 1'b0;
    end else if (wr_now && hit(ph_addr, `SIA_OFS_START) && I_HWDATA[0]) begin
      chan_enabled <= 1'b1;
    end else if (wr_now && hit(ph_addr, `SIA_OFS_STOP) && I_HWDATA[0]) begin
      chan_enabled <= 1'b0;
    end
  end

  // ==================================================
  // Ack error flag: hardware set wins over software clear
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ack_err <= 1'b0;
    end else if (sh_ack_bad) begin
      ack_err <= 1'b1;
    end else if (wr_now && hit(ph_addr, `SIA_OFS_FLAGCLR) && I_HWDATA[`SIA_STAT_ACKERR]) begin
      ack_err <= 1'b0;
    end
  end

  // ==================================================
  // Transfer end event, the only event the channel raises
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_XFER_END <= 1'b0;
    end else begin
      O_XFER_END <= sh_done;
    end
  end

  // ==================================================
  // Two-stage synchronisers for the bus lines
  // Clock line is only watched; no stretch detection is done
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sda_sync <= 2'b11;
      scl_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], I_SDA};
      scl_sync <= {scl_sync[0], I_SCL};
    end
  end

  // ==================================================
  // Operation clock from the selected prescaler output
  sia_prescaler u_presc (
    .i_clk     (I_CLOCK),
    .i_rst_n   (I_RSTN),
    .i_setting (prescale),
    .i_sel     (mode_cfg[`SIA_MODE_CKSEL]),
    .o_tick    (mck_tick)
  );

  // ==================================================
  // Frame engine; master only, it always drives the clock
  sia_shifter u_shift (
    .i_clk     (I_CLOCK),
    .i_rst_n   (I_RSTN),
    .i_tick    (mck_tick),
    .i_start   (start_req),
    .i_div     (data_div[`SIA_DATA_DIV_HI:`SIA_DATA_DIV_LO]),
    .i_tx      (data_div[7:0]),
    .i_txe     (comm_set[`SIA_COMM_TXE]),
    .i_rxe     (comm_set[`SIA_COMM_RXE]),
    .i_ack_en  (out_en[0]),
    .i_sda     (sda_sync[1]),
    .o_busy    (sh_busy),
    .o_scl     (sh_scl),
    .o_sda     (sh_sda),
    .o_rx      (sh_rx),
    .o_done    (sh_done),
    .o_ack_bad (sh_ack_bad)
  );

  // ==================================================
  // Open-drain pins: only a low level is driven
  // While output is disabled the data pin follows the level bit,
  // which is how software shapes start and stop conditions
  wire sda_level = (out_en[0] && sh_busy) ? sh_sda
                                          : out_lvl[`SIA_OUTLVL_DATA];
  wire scl_level = sh_busy ? sh_scl : out_lvl[`SIA_OUTLVL_CLK];

  assign O_SDA_O    = 1'b0;
  assign O_SDA_OE_N = sda_level;
  assign O_SCL_O    = 1'b0;
  assign O_SCL_OE_N = scl_level;

endmodule

// ===== common/sia_defines.vh
// Contract
// - Single master only; no slave, arbitration, wait
// - Used solely as master for single transfers
// - Frame is 8 bits: address plus R/W
// - Drives acknowledge and detects slave acknowledge
// - Missing acknowledge sets ack error flag only
// - Output enable 0 suppresses acknowledge on last byte
// - Address, data transmit, receive, stop operations
// - Address and direction sent in one frame
// - No parity; one acknowledge slot appended
// - Clock select picks prescaler output 0 or 1
// - Low byte data, upper bits baud divider
`ifndef SIA_DEFINES_VH
`define SIA_DEFINES_VH

// ==================================================
// Register byte offsets
`define SIA_OFS_MODE      8'h00
`define SIA_OFS_COMM      8'h04
`define SIA_OFS_DATA      8'h08
`define SIA_OFS_OUTLVL    8'h0c
`define SIA_OFS_OUTEN     8'h10
`define SIA_OFS_START     8'h14
`define SIA_OFS_STOP      8'h18
`define SIA_OFS_STATUS    8'h1c
`define SIA_OFS_FLAGCLR   8'h20
`define SIA_OFS_PRESCALE  8'h24
`define SIA_OFS_ENABLED   8'h28

// ==================================================
// Field positions
`define SIA_MODE_CKSEL    15
`define SIA_MODE_IRQSRC   0
`define SIA_COMM_TXE      15
`define SIA_COMM_RXE      14
`define SIA_DATA_DIV_HI   15
`define SIA_DATA_DIV_LO   9
`define SIA_OUTLVL_CLK    8
`define SIA_OUTLVL_DATA   0
`define SIA_STAT_BUSY     6
`define SIA_STAT_ACKERR   1

// ==================================================
// Reset values
`define SIA_RST_MODE      16'h0020
`define SIA_RST_COMM      16'h0087
`define SIA_RST_DATA      16'h0000
`define SIA_RST_OUTLVL    16'h0f0f
`define SIA_RST_OUTEN     16'h0000
`define SIA_RST_PRESCALE  8'h00

// ==================================================
// Timing: frame bit count, last data bit index
`define SIA_FRAME_BITS    4'h9
`define SIA_LAST_DATA_BIT 4'h7
`define SIA_ACK_BIT       4'h8

`endif

// ===== core/sia_prescaler.v
`timescale 1ns/1ps
`include "sia_defines.vh"

module sia_prescaler (
  input  wire       i_clk,     // System clock
  input  wire       i_rst_n,   // Async reset, active low
  input  wire [7:0] i_setting, // Two 4-bit power-of-two divisors
  input  wire       i_sel,     // Channel clock select
  output reg        o_tick     // Operation clock enable pulse
);

  reg  [15:0] cnt;
  wire [1:0]  out_tick;

  // Tick when the low ps bits of the free counter are all zero
  function tick_of;
    input [15:0] c;
    input [3:0]  ps;
    begin
      tick_of = ((c & ((16'h0001 << ps) - 16'h0001)) == 16'h0000);
    end
  endfunction

  // ==================================================
  // Free running divider shared by both outputs
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Both prescaler outputs from one counter keeps them phase aligned
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_out
      assign out_tick[g] = tick_of(cnt, i_setting[4*g+3:4*g]);
    end
  endgenerate

  // Registered select of the channel operation clock
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_sel ? out_tick[1] : out_tick[0];
    end
  end

endmodule

// ===== core/sia_shifter.v
`timescale 1ns/1ps
`include "sia_defines.vh"

module sia_shifter (
  input  wire       i_clk,      // System clock
  input  wire       i_rst_n,    // Async reset, active low
  input  wire       i_tick,     // Operation clock enable
  input  wire       i_start,    // Launch one frame
  input  wire [6:0] i_div,      // Half period in ticks minus one
  input  wire [7:0] i_tx,       // Byte to send
  input  wire       i_txe,      // Transmit enabled
  input  wire       i_rxe,      // Receive enabled
  input  wire       i_ack_en,   // Output enable, gates ack drive
  input  wire       i_sda,      // Synchronised data line
  output reg        o_busy,     // Frame in progress
  output reg        o_scl,      // Clock level while busy
  output reg        o_sda,      // Data level while busy
  output reg  [7:0] o_rx,       // Received byte
  output reg        o_done,     // Frame end pulse
  output reg        o_ack_bad   // Missing ack pulse
);

  localparam ST_IDLE = 2'b00;
  localparam ST_LOW  = 2'b01;
  localparam ST_HIGH = 2'b10;

  reg [1:0] state;
  reg [6:0] hcnt;
  reg [3:0] bitn;
  reg [7:0] sh;

  wire half_end = i_tick && (hcnt == i_div);

  // ==================================================
  // Bit engine: each bit is a low half then a high half
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= ST_IDLE;
      hcnt      <= 7'h00;
      bitn      <= 4'h0;
      sh        <= 8'h00;
      o_busy    <= 1'b0;
      o_scl     <= 1'b0;
      o_sda     <= 1'b1;
      o_rx      <= 8'h00;
      o_done    <= 1'b0;
      o_ack_bad <= 1'b0;
    end else begin
      o_done    <= 1'b0;
      o_ack_bad <= 1'b0;
      if (i_tick && state != ST_IDLE) begin
        hcnt <= half_end ? 7'h00 : hcnt + 7'h01;
      end
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            state  <= ST_LOW;
            hcnt   <= 7'h00;
            bitn   <= 4'h0;
            sh     <= i_tx;
            o_busy <= 1'b1;
            o_scl  <= 1'b0;
            o_sda  <= i_txe ? i_tx[7] : 1'b1;
          end
        end
        ST_LOW: begin
          if (half_end) begin
            state <= ST_HIGH;
            o_scl <= 1'b1;
            if (bitn == `SIA_ACK_BIT) begin
              o_ack_bad <= i_txe && i_sda;
            end else if (i_rxe) begin
              o_rx <= {o_rx[6:0], i_sda};
            end
          end
        end
        ST_HIGH: begin
          if (half_end) begin
            o_scl <= 1'b0;
            if (bitn == `SIA_ACK_BIT) begin
              state  <= ST_IDLE;
              o_busy <= 1'b0;
              o_done <= 1'b1;
            end else begin
              state <= ST_LOW;
              bitn  <= bitn + 4'h1;
              sh    <= {sh[6:0], 1'b0};
              if (bitn == `SIA_LAST_DATA_BIT) begin
                o_sda <= !(i_rxe && !i_txe && i_ack_en);
              end else begin
                o_sda <= i_txe ? sh[6] : 1'b1;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== tb/sia_assertions.sv
`timescale 1ns/1ps
`include "sia_defines.vh"
// ====================
// Bus and frame checks
module sia_assertions (
  input logic        I_CLOCK,     // Clock
  input logic        I_RSTN,      // Reset
  input logic        I_HSEL,      // Select
  input logic [31:0] I_HADDR,     // Address
  input logic [1:0]  I_HTRANS,    // Type
  input logic        I_HWRITE,    // Write
  input logic        I_HREADY,    // Ready in
  input logic        O_HREADYOUT, // Ready out
  input logic        O_SDA_O,     // Data value
  input logic        O_SDA_OE_N,  // Data drive
  input logic        O_SCL_O,     // Clock value
  input logic        O_SCL_OE_N,  // Clock drive
  input logic        O_XFER_END   // Frame end
);
  logic        wr_pend;
  logic        in_frame;
  logic        scl_q;
  logic [3:0]  rises;
  logic [11:0] fcnt;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  // Window from a data write to its end pulse; busy writes never happen here
  always @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_pend <= 1'b0;
      in_frame <= 1'b0;
      scl_q <= 1'b1;
      rises <= 4'h0;
      fcnt <= 12'h000;
    end else begin
      wr_pend <= I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE & (I_HADDR[7:0] == `SIA_OFS_DATA);
      scl_q <= O_SCL_OE_N;
      if (wr_pend) begin
        in_frame <= 1'b1;
        rises <= 4'h0;
        fcnt <= 12'h000;
      end else if (O_XFER_END) begin
        in_frame <= 1'b0;
      end else if (in_frame) begin
        fcnt <= fcnt + 12'h001;
        rises <= rises + {3'h0, O_SCL_OE_N & ~scl_q};
      end
    end
  end
  // ====================
  // Sequences
  sequence s_taken;
    I_HSEL && I_HTRANS[1] && I_HREADY;
  endsequence
  sequence s_rd;
    s_taken ##0 !I_HWRITE;
  endsequence
  sequence s_wr;
    s_taken ##0 I_HWRITE;
  endsequence
  sequence s_rd_ans;
    !O_HREADYOUT ##1 O_HREADYOUT;
  endsequence
  // ====================
  // Assertions
  AST_RD_WAIT: assert property (s_rd |=> s_rd_ans)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (s_wr |=> O_HREADYOUT)
    else $error("write stalled");
  AST_OPEN_DRAIN: assert property (!O_SDA_O && !O_SCL_O)
    else $error("line driven high");
  AST_END_PULSE: assert property (O_XFER_END |=> !O_XFER_END)
    else $error("end pulse too long");
  AST_END_IN_FRAME: assert property (O_XFER_END |-> in_frame)
    else $error("end pulse without frame");
  AST_NINE_CLOCKS: assert property (O_XFER_END |-> rises == 4'h9)
    else $error("clock count per frame wrong");
  AST_FRAME_LEN: assert property (O_XFER_END |-> fcnt >= 12'd36 && fcnt <= 12'd2400)
    else $error("frame length out of range");
  AST_SDA_HOLD: assert property (in_frame && O_SCL_OE_N && $past(O_SCL_OE_N) |-> $stable(O_SDA_OE_N))
    else $error("data moved under high clock");
endmodule

bind sia_top sia_assertions sia_assertions_inst (
  .I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
  .O_HREADYOUT(O_HREADYOUT), .O_SDA_O(O_SDA_O), .O_SDA_OE_N(O_SDA_OE_N),
  .O_SCL_O(O_SCL_O), .O_SCL_OE_N(O_SCL_OE_N), .O_XFER_END(O_XFER_END)
);

// ===== tb/sia_slave_model.sv
`timescale 1ns/1ps
// ====================
// Slave: acks on request, returns one byte after a read address
module sia_slave_model (
  input  wire       i_clk,      // Clock
  input  wire       i_rst_n,    // Reset
  input  wire       i_scl,      // Clock line
  input  wire       i_sda,      // Data line
  input  wire       i_ack_en,   // Ack when high
  input  wire [7:0] i_tx,       // Read byte
  output reg        o_sda_n,    // Low pulls data
  output reg  [7:0] o_rx,       // Byte shifted in
  output reg        o_ack_seen, // Ack slot level
  output reg  [7:0] o_hi_len    // Last high length
);
  reg       scl_q;
  reg       sda_q;
  reg       rd;
  reg       first;
  reg [3:0] bit_n;
  reg [7:0] hi;
  // Index of the bit that the next low clock half carries
  wire [3:0] nb = (bit_n == 4'h8) ? 4'h0 : bit_n + 4'h1;
  // Lines sampled each clock; a released line reads as the pull-up
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {scl_q, sda_q, o_sda_n} <= 3'h7;
      {rd, first, o_ack_seen} <= 3'h0;
      bit_n <= 4'h8;
      o_rx <= 8'h00;
      o_hi_len <= 8'h00;
      hi <= 8'h00;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      hi <= i_scl ? hi + 8'h01 : 8'h00;
      if (i_scl && scl_q && sda_q && !i_sda) begin
        bit_n <= 4'h8;
        first <= 1'b1;
        rd <= 1'b0;
      end else if (i_scl && !scl_q) begin
        if (bit_n < 4'h8) begin
          o_rx <= {o_rx[6:0], i_sda};
        end else begin
          o_ack_seen <= i_sda;
          rd <= first & o_rx[0] & i_ack_en;
          first <= 1'b0;
        end
      end else if (!i_scl && scl_q) begin
        o_hi_len <= hi;
        bit_n <= nb;
        // Data bits only while reading; otherwise only the ack slot is pulled
        o_sda_n <= rd ? (nb == 4'h8 || i_tx[3'h7 - nb[2:0]]) : ~(nb == 4'h8 && i_ack_en);
      end
    end
  end
endmodule

// ===== tb/test_simple_i2c_master_address_phase.sv
`timescale 1ns/1ps
module test_simple_i2c_master_address_phase;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire         hready;
  wire  [31:0] hrdata;
  wire         sda_oe_n;
  wire         scl_oe_n;
  wire         slv_sda_n;
  wire         xfer_end;
  wire         ack_seen;
  wire  [7:0]  slv_rx;
  wire  [7:0]  hi_len;
  logic        ack;
  logic [7:0]  slv_tx;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [6:0]  dv;
  logic [3:0]  e0;
  logic [3:0]  e1;
  logic        cks;
  logic        rw;
  logic        oe;
  logic [7:0]  tx_b;
  integer      miscompares;
  integer      checked;
  integer      i;
  logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h1c, 8'h24, 8'h3c};
  logic [31:0] rv [8] = '{32'h20, 32'h87, 32'h0, 32'h0f0f, 32'h0, 32'h0, 32'h0, 32'h0};
  wire         sda_w = sda_oe_n & slv_sda_n; // Open drain with pull-up
  sia_top sia_top_inst (
    .I_CLOCK(clk), .I_RSTN(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HREADYOUT(hready), .O_HRESP(), .O_HRDATA(hrdata), .I_SDA(sda_w), .O_SDA_O(),
    .O_SDA_OE_N(sda_oe_n), .I_SCL(scl_oe_n), .O_SCL_O(), .O_SCL_OE_N(scl_oe_n),
    .O_XFER_END(xfer_end));
  sia_slave_model sia_slave_model_inst (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl_oe_n), .i_sda(sda_w), .i_ack_en(ack),
    .i_tx(slv_tx), .o_sda_n(slv_sda_n), .o_rx(slv_rx), .o_ack_seen(ack_seen), .o_hi_len(hi_len));
  // ====================
  // Helpers
  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function logic [31:0] half_len(input logic [6:0] d, input logic [3:0] e);
    half_len = ({25'h0, d} + 32'h1) << e;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (miscompares == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Single transfer; the watchdog is the only end of a hung wait
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge clk);
      while (hready !== 1'b1)
        @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1)
        @(posedge clk);
      rd = hrdata;
    end
  endtask
  task wait_end;
    begin
      @(posedge clk);
      while (xfer_end !== 1'b1)
        @(posedge clk);
    end
  endtask
  // Outputs off, both lines high, data low, then clock low
  task make_start;
    begin
      bus(1, 8'h10, 32'h0);
      bus(1, 8'h0c, 32'h0f0f);
      bus(1, 8'h0c, 32'h0f0e);
      bus(1, 8'h0c, 32'h0e0e);
      bus(1, 8'h10, 32'h1);
    end
  endtask
  // ====================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    miscompares = miscompares + 1;
    complete_run;
  end
  // ====================
  // Main sequence
  initial begin
    {rst_n, htrans, hwrite, haddr, hwdata, ack, slv_tx} = '0;
    hsel = 1'b1;
    seed = 32'hac27;
    miscompares = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      bus(0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    bus(1, 8'h3c, 32'hffff);
    bus(0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    // Early passes force a refused ack, an acked read, a read without ack
    for (i = 0; i < 10; i = i + 1) begin
      seed = xs(seed);
      dv = 7'h3 + {5'h0, seed[1:0]};
      e0 = 4'h3 + {3'h0, seed[2]};
      e1 = 4'h4 - {3'h0, seed[2]};
      cks = seed[3];
      ack <= (i == 0) ? 1'b0 : ((i < 3) | seed[4]);
      rw = (i == 1 || i == 2) | seed[5];
      oe = (i == 2) ? 1'b0 : ((i == 1) | seed[13]);
      tx_b = {seed[12:6], rw};
      slv_tx <= seed[21:14];
      bus(1, 8'h24, {24'h0, e1, e0});
      bus(1, 8'h00, {16'h0, cks, 15'h0020});
      bus(1, 8'h04, 32'h8017);
      make_start;
      if (i == 0) begin
        bus(1, 8'h14, 32'h1);
        bus(0, 8'h28, 32'h0);
        chk(rd, 32'h1);
      end
      bus(1, 8'h08, {16'h0, dv, 1'b0, tx_b});
      wait_end;
      chk({24'h0, slv_rx}, {24'h0, tx_b});
      bus(0, 8'h1c, 32'h0);
      chk(rd & 32'h2, {30'h0, ~ack, 1'b0});
      chk({24'h0, hi_len}, half_len(dv, cks ? e1 : e0));
      chk({31'h0, ack_seen}, {31'h0, ~ack});
      bus(1, 8'h20, rd);
      bus(0, 8'h1c, 32'h0);
      chk(rd & 32'h2, 32'h0);
      if (rw && ack) begin
        bus(1, 8'h04, 32'h4017);
        if (!oe) begin
          bus(1, 8'h0c, 32'h0e0f);
          bus(1, 8'h10, 32'h0);
        end
        bus(1, 8'h08, {16'h0, dv, 9'h0ff});
        wait_end;
        bus(0, 8'h08, 32'h0);
        chk(rd & 32'hff, {24'h0, slv_tx});
        chk({31'h0, ack_seen}, {31'h0, ~oe});
      end
    end
    complete_run;
  end
endmodule
